// ### common/amd_defines.vh
// Constants for the addressing mode decoder: mode, group and prebyte codes.
// Assumes the opcode decoder outside supplies the X based mode and group.
// Behaviour
// - Inherent instruction is one byte, no operands.
// - Immediate: opcode plus one operand value byte.
// - Short direct: one address byte, range 00-FF.
// - Long direct: two address bytes, full space.
// - Indexed address is unsigned index plus offset.
// - No-offset indexed: no byte, address equals index.
// - Short indexed: one offset byte, reaches 1FE.
// - Long indexed: two offset bytes, full space.
// - Short indirect: pointer address, byte pointer read.
// - Long indirect: pointer address, word pointer read.
// - Indirect indexed: index plus pointer from memory.
// - Indirect indexed: byte or word pointer, one byte.
// - Relative: PC plus signed 8-bit offset.
// - Relative direct: offset follows the opcode.
// - Relative indirect: offset read from given address.
// - Relative modes only for branches and relative call.
// - Thirteen groups, sixty-three instructions recognised.
// - Load, compare, logic, arithmetic accept long forms.
// - Other memory groups except stack accept short forms only.
// - Mask set gives level 3, clear level 0.
// - One-byte trap, wait and halt requests.
// - Prebytes select second index or indirect forms.
// - Short direct and indirect forms page zero; memory-to-memory short only.
`ifndef AMD_DEFINES_VH
`define AMD_DEFINES_VH

// Addressing modes, in their X based, unprefixed meaning.
`define AMD_M_INH    4'h0
`define AMD_M_IMM    4'h1
`define AMD_M_DIR_S  4'h2
`define AMD_M_DIR_L  4'h3
`define AMD_M_IDX0   4'h4
`define AMD_M_IDX_S  4'h5
`define AMD_M_IDX_L  4'h6
`define AMD_M_IND_S  4'h7
`define AMD_M_IND_L  4'h8
`define AMD_M_INDX_S 4'h9
`define AMD_M_INDX_L 4'hA
`define AMD_M_REL_D  4'hB
`define AMD_M_REL_I  4'hC

// Instruction groups.
`define AMD_G_LOAD   4'h0
`define AMD_G_STACK  4'h1
`define AMD_G_INCDEC 4'h2
`define AMD_G_CMP    4'h3
`define AMD_G_LOGIC  4'h4
`define AMD_G_BIT    4'h5
`define AMD_G_BTJ    4'h6
`define AMD_G_ARITH  4'h7
`define AMD_G_SHIFT  4'h8
`define AMD_G_JUMP   4'h9
`define AMD_G_CBR    4'hA
`define AMD_G_IRQ    4'hB
`define AMD_G_FLAG   4'hC
`define AMD_GROUPS   4'hD
`define AMD_INSTRS   8'h3F

// Prebyte codes.
`define AMD_PRE_NONE 8'h00
`define AMD_PRE_Y    8'h90
`define AMD_PRE_IY   8'h91
`define AMD_PRE_IND  8'h92

// Inherent operations with side effects.
`define AMD_I_NONE   3'h0
`define AMD_I_TRAP   3'h1
`define AMD_I_WAIT_FOR_IRQ_OP 3'h2
`define AMD_I_HALT   3'h3
`define AMD_I_MSET   3'h4
`define AMD_I_MCLR   3'h5

// Interrupt mask levels and page zero high byte.
`define AMD_MASK_L3  2'h3
`define AMD_MASK_L0  2'h0
`define AMD_PAGE0    8'h00

`endif

// ### rtl/amd_addr_adder.v
// Address adder: a 16-bit base plus an 8-bit value.
// Assumes the caller registers the result; purely combinational.
`timescale 1ns/1ps
module amd_addr_adder (
    base,
    delta,
    signed_add,
    sum
);
    input  wire [15:0] base;
    input  wire [7:0]  delta;
    input  wire        signed_add;
    output wire [15:0] sum;

    wire [15:0] ext;

    // Index values are zero-extended; relative offsets are sign-extended.
    assign ext = signed_add ? {{8{delta[7]}}, delta} : {8'h00, delta};
    // Wraps at 64 Kbyte, which is the whole space anyway.
    assign sum = base + ext;
endmodule

// ### rtl/amd_decoder.v
// Addressing mode decoder: operand fetch and effective address forming.
// Assumes one memory port on clk_sys answering each read with mem_ack,
// and an opcode decoder that presents mode, group and prebyte at start.
// All inputs come from logic on clk_sys, so none of them is synchronised.
`timescale 1ns/1ps
`include "amd_defines.vh"
module amd_decoder (
    clk_sys,
    rstn,
    start,
    opc_pc,
    prebyte,
    base_mode,
    group,
    rmw_op,
    inh_op,
    idx_x,
    idx_y,
    mem_rdata,
    mem_ack,
    mem_rd_reg,
    mem_addr_reg,
    busy_reg,
    done_reg,
    illegal_reg,
    len_reg,
    next_pc_reg,
    ea_reg,
    imm_reg,
    target_reg,
    irq_mask_reg,
    swi_reg,
    wait_for_irq_op_reg,
    halt_reg
);
    input  wire        clk_sys;
    input  wire        rstn;
    input  wire        start;
    input  wire [15:0] opc_pc;
    input  wire [7:0]  prebyte;
    input  wire [3:0]  base_mode;
    input  wire [3:0]  group;
    input  wire        rmw_op;
    input  wire [2:0]  inh_op;
    input  wire [7:0]  idx_x;
    input  wire [7:0]  idx_y;
    input  wire [7:0]  mem_rdata;
    input  wire        mem_ack;
    output reg         mem_rd_reg;
    output reg  [15:0] mem_addr_reg;
    output reg         busy_reg;
    output reg         done_reg;
    output reg         illegal_reg;
    output reg  [1:0]  len_reg;
    output reg  [15:0] next_pc_reg;
    output reg  [15:0] ea_reg;
    output reg  [7:0]  imm_reg;
    output reg  [15:0] target_reg;
    output reg  [1:0]  irq_mask_reg;
    output reg         swi_reg;
    output reg         wait_for_irq_op_reg;
    output reg         halt_reg;

    // Sequencer states. Calculation is the default branch of the case, so a
    // corrupted state code falls into it and returns to idle within a cycle.
    localparam ST_IDLE = 2'h0;
    localparam ST_OPND = 2'h1;
    localparam ST_PTR  = 2'h2;
    localparam ST_CALC = 2'h3;

    // Instruction context, captured at start and held until done, so the
    // opcode decoder is free to present the next instruction early.
    reg  [1:0]  state_reg;
    reg  [1:0]  cnt_reg;
    reg  [3:0]  mode_reg;
    reg  [2:0]  inh_reg;
    reg  [7:0]  idx_reg;
    reg  [15:0] val_reg;

    // Combinational decode of the presented instruction, valid with start.
    reg  [3:0]  eff_mode;
    reg         pre_bad;
    reg         grp_bad;
    reg  [1:0]  n_opnd;
    reg         is_long;

    // Decode of the captured mode, used while operands arrive and at the end.
    wire        is_rel;
    wire        use_idx;
    wire        need_ptr;
    wire        ptr_word;

    // Shared adder operands: one adder serves indexed and relative forms.
    wire [15:0] add_base;
    wire [7:0]  add_delta;
    wire [15:0] add_sum;

    // The indirect prebytes rewrite the X based mode to its indirect counterpart.
    always @* begin
        eff_mode = base_mode;
        pre_bad  = 1'b0;
        case (prebyte)
            `AMD_PRE_NONE: pre_bad = 1'b0;
            `AMD_PRE_Y: begin
                if (base_mode > `AMD_M_IDX_L)
                    pre_bad = 1'b1;
            end
            `AMD_PRE_IND, `AMD_PRE_IY: begin
                case (base_mode)
                    `AMD_M_DIR_S: eff_mode = `AMD_M_IND_S;
                    `AMD_M_DIR_L: eff_mode = `AMD_M_IND_L;
                    `AMD_M_IDX_S: eff_mode = `AMD_M_INDX_S;
                    `AMD_M_IDX_L: eff_mode = `AMD_M_INDX_L;
                    `AMD_M_REL_D: eff_mode = `AMD_M_REL_I;
                    default:      pre_bad = 1'b1;
                endcase
                // The Y indirect prebyte only exists for indexed forms.
                if (prebyte == `AMD_PRE_IY && base_mode != `AMD_M_IDX_S
                    && base_mode != `AMD_M_IDX_L)
                    pre_bad = 1'b1;
            end
            // Any other value is not a prebyte; refusing it keeps a stray
            // opcode byte from being decoded as an extension.
            default: pre_bad = 1'b1;
        endcase
    end

    // Bytes after the opcode for each mode.
    always @* begin
        case (eff_mode)
            `AMD_M_INH:    n_opnd = 2'd0;
            `AMD_M_IMM:    n_opnd = 2'd1;
            `AMD_M_DIR_S:  n_opnd = 2'd1;
            `AMD_M_DIR_L:  n_opnd = 2'd2;
            `AMD_M_IDX0:   n_opnd = 2'd0;
            `AMD_M_IDX_S:  n_opnd = 2'd1;
            `AMD_M_IDX_L:  n_opnd = 2'd2;
            `AMD_M_REL_D:  n_opnd = 2'd1;
            // Every pointer form carries only its pointer address here; the
            // pointer itself is read from page zero afterwards.
            default:       n_opnd = 2'd1;
        endcase
    end

    // Which group may use which mode; unknown groups are refused.
    always @* begin
        is_long = (eff_mode == `AMD_M_DIR_L) || (eff_mode == `AMD_M_IDX_L) ||
                  (eff_mode == `AMD_M_IND_L) || (eff_mode == `AMD_M_INDX_L);
        grp_bad = 1'b0;
        if (group >= `AMD_GROUPS)
            grp_bad = 1'b1;
        if ((eff_mode == `AMD_M_REL_D || eff_mode == `AMD_M_REL_I) &&
            group != `AMD_G_CBR && group != `AMD_G_JUMP)
            grp_bad = 1'b1;
        if (is_long && (rmw_op || group == `AMD_G_INCDEC || group == `AMD_G_BIT ||
            group == `AMD_G_BTJ || group == `AMD_G_SHIFT || group == `AMD_G_JUMP))
            grp_bad = 1'b1;
        if (eff_mode == `AMD_M_IMM && group != `AMD_G_LOAD && group != `AMD_G_CMP &&
            group != `AMD_G_LOGIC && group != `AMD_G_ARITH)
            grp_bad = 1'b1;
        // Codes above the last mode are spare and refused outright.
        if (eff_mode > `AMD_M_REL_I)
            grp_bad = 1'b1;
    end

    assign is_rel   = (mode_reg == `AMD_M_REL_D) || (mode_reg == `AMD_M_REL_I);
    assign use_idx  = (mode_reg == `AMD_M_IDX0) || (mode_reg == `AMD_M_IDX_S) ||
                      (mode_reg == `AMD_M_IDX_L) || (mode_reg == `AMD_M_INDX_S) ||
                      (mode_reg == `AMD_M_INDX_L);
    assign need_ptr = (mode_reg == `AMD_M_IND_S) || (mode_reg == `AMD_M_IND_L) ||
                      (mode_reg == `AMD_M_INDX_S) || (mode_reg == `AMD_M_INDX_L) ||
                      (mode_reg == `AMD_M_REL_I);
    assign ptr_word = (mode_reg == `AMD_M_IND_L) || (mode_reg == `AMD_M_INDX_L);

    // Relative forms add to the PC past the instruction, others to the value.
    assign add_base  = is_rel ? next_pc_reg : val_reg;
    assign add_delta = is_rel ? val_reg[7:0] : (use_idx ? idx_reg : 8'h00);

    amd_addr_adder u_add (
        .base       (add_base),
        .delta      (add_delta),
        .signed_add (is_rel),
        .sum        (add_sum)
    );

    // Sequencer: operand bytes, optional pointer, then one result cycle.
    always @(posedge clk_sys or negedge rstn) begin
        if (!rstn) begin
            state_reg    <= ST_IDLE;
            cnt_reg      <= 2'd0;
            mode_reg     <= `AMD_M_INH;
            inh_reg      <= `AMD_I_NONE;
            idx_reg      <= 8'h00;
            val_reg      <= 16'h0000;
            mem_rd_reg   <= 1'b0;
            mem_addr_reg <= 16'h0000;
            busy_reg     <= 1'b0;
            done_reg     <= 1'b0;
            illegal_reg  <= 1'b0;
            len_reg      <= 2'd0;
            next_pc_reg  <= 16'h0000;
            ea_reg       <= 16'h0000;
            imm_reg      <= 8'h00;
            target_reg   <= 16'h0000;
            // Interrupts come out of reset masked at the highest level.
            irq_mask_reg <= `AMD_MASK_L3;
            swi_reg      <= 1'b0;
            wait_for_irq_op_reg <= 1'b0;
            halt_reg     <= 1'b0;
        end else begin
            done_reg <= 1'b0;
            swi_reg  <= 1'b0;
            wait_for_irq_op_reg <= 1'b0;
            halt_reg <= 1'b0;
            case (state_reg)
                ST_IDLE: begin
                    if (start) begin
                        busy_reg    <= 1'b1;
                        mode_reg    <= eff_mode;
                        inh_reg     <= inh_op;
                        illegal_reg <= pre_bad | grp_bad;
                        // Second index register under either Y prebyte.
                        idx_reg     <= (prebyte == `AMD_PRE_Y || prebyte == `AMD_PRE_IY) ?
                                       idx_y : idx_x;
                        val_reg     <= 16'h0000;
                        // Length counts the opcode but never the prebyte.
                        len_reg     <= n_opnd + 2'd1;
                        next_pc_reg <= opc_pc + {14'h0000, n_opnd} + 16'h0001;
                        cnt_reg     <= n_opnd;
                        // A refused instruction skips every read, so an illegal
                        // combination never disturbs memory.
                        if (pre_bad || grp_bad || n_opnd == 2'd0) begin
                            state_reg <= ST_CALC;
                        end else begin
                            mem_addr_reg <= opc_pc + 16'h0001;
                            mem_rd_reg   <= 1'b1;
                            state_reg    <= ST_OPND;
                        end
                    end
                end
                ST_OPND: begin
                    if (mem_ack) begin
                        // Bytes shift in from the low end, so the first one
                        // fetched ends up as the high byte of a word.
                        val_reg      <= {val_reg[7:0], mem_rdata};
                        cnt_reg      <= cnt_reg - 2'd1;
                        mem_addr_reg <= mem_addr_reg + 16'h0001;
                        if (cnt_reg == 2'd1) begin
                            if (need_ptr) begin
                                // Pointers always live in page zero.
                                mem_addr_reg <= {`AMD_PAGE0, mem_rdata};
                                cnt_reg      <= ptr_word ? 2'd2 : 2'd1;
                                val_reg      <= 16'h0000;
                                state_reg    <= ST_PTR;
                            end else begin
                                mem_rd_reg <= 1'b0;
                                state_reg  <= ST_CALC;
                            end
                        end
                    end
                end
                // The request stays up between the last operand byte and the
                // first pointer byte; only its address moves.
                ST_PTR: begin
                    if (mem_ack) begin
                        val_reg      <= {val_reg[7:0], mem_rdata};
                        cnt_reg      <= cnt_reg - 2'd1;
                        mem_addr_reg <= mem_addr_reg + 16'h0001;
                        if (cnt_reg == 2'd1) begin
                            mem_rd_reg <= 1'b0;
                            state_reg  <= ST_CALC;
                        end
                    end
                end
                default: begin
                    // A refused instruction still reports, but has no side effect.
                    state_reg  <= ST_IDLE;
                    busy_reg   <= 1'b0;
                    done_reg   <= 1'b1;
                    imm_reg    <= val_reg[7:0];
                    target_reg <= is_rel ? add_sum : next_pc_reg;
                    if (mode_reg == `AMD_M_DIR_S || mode_reg == `AMD_M_IND_S)
                        ea_reg <= {`AMD_PAGE0, val_reg[7:0]};
                    else if (use_idx)
                        ea_reg <= add_sum;
                    else
                        ea_reg <= val_reg;
                    // Side effects only for legal inherent forms; the mask keeps
                    // its level for every other instruction.
                    if (!illegal_reg && mode_reg == `AMD_M_INH) begin
                        case (inh_reg)
                            `AMD_I_TRAP: swi_reg  <= 1'b1;
                            `AMD_I_WAIT_FOR_IRQ_OP: wait_for_irq_op_reg <= 1'b1;
                            `AMD_I_HALT: halt_reg <= 1'b1;
                            `AMD_I_MSET: irq_mask_reg <= `AMD_MASK_L3;
                            `AMD_I_MCLR: irq_mask_reg <= `AMD_MASK_L0;
                            default:     irq_mask_reg <= irq_mask_reg;
                        endcase
                    end
                end
            endcase
        end
    end
endmodule

// ### testbench/amd_decoder_checker.sv
// Port-level assertions for the addressing mode decoder.
// Assumes amd_defines.vh on the include path; bound from the bench top.
`timescale 1ns/1ps
`include "amd_defines.vh"
module amd_decoder_checker (
    input logic        clk_sys,
    input logic        rstn,
    input logic        start,
    input logic [15:0] opc_pc,
    input logic [7:0]  prebyte,
    input logic [3:0]  base_mode,
    input logic [3:0]  group,
    input logic [2:0]  inh_op,
    input logic [7:0]  idx_x,
    input logic        mem_ack,
    input logic        mem_rd_reg,
    input logic [15:0] mem_addr_reg,
    input logic        busy_reg,
    input logic        done_reg,
    input logic        illegal_reg,
    input logic [1:0]  len_reg,
    input logic [15:0] next_pc_reg,
    input logic [15:0] ea_reg,
    input logic [1:0]  irq_mask_reg,
    input logic        halt_reg
);
    logic [3:0]  mode_reg;
    logic [7:0]  pre_reg;
    logic [7:0]  x_reg;
    logic [2:0]  op_reg;
    logic [15:0] pc_reg;
    wire         take = start && !busy_reg;
    wire         ok   = done_reg && !illegal_reg;

    // Inputs are only valid with start, so keep them for judging the later done.
    always_ff @(posedge clk_sys or negedge rstn) begin
        if (!rstn) begin
            {mode_reg, pre_reg, x_reg, op_reg, pc_reg} <= '0;
        end else if (take) begin
            {mode_reg, pre_reg, x_reg, op_reg, pc_reg} <=
                {base_mode, prebyte, idx_x, inh_op, opc_pc};
        end
    end

    default clocking @(posedge clk_sys); endclocking
    default disable iff (!rstn);

    a_inh_timing: assert property (take && base_mode == `AMD_M_INH
        |=> busy_reg ##1 done_reg)
        else $error("inherent decode not done two cycles after start");
    a_inh_noread: assert property (take && base_mode == `AMD_M_INH
        |=> !mem_rd_reg [*2])
        else $error("inherent decode issued a memory read");
    a_inh_len: assert property (ok && mode_reg == `AMD_M_INH |-> len_reg == 2'd1)
        else $error("inherent length is not one byte");
    a_next_pc: assert property (ok |-> next_pc_reg == pc_reg + 16'(len_reg))
        else $error("next pc does not follow the opcode by the length");
    a_mask_set: assert property (ok && mode_reg == `AMD_M_INH
        && op_reg == `AMD_I_MSET |-> irq_mask_reg == `AMD_MASK_L3)
        else $error("mask set did not give level 3");
    a_mask_clear: assert property (ok && mode_reg == `AMD_M_INH
        && op_reg == `AMD_I_MCLR |-> irq_mask_reg == `AMD_MASK_L0)
        else $error("mask clear did not give level 0");
    a_idx0_ea: assert property (ok && mode_reg == `AMD_M_IDX0
        && pre_reg == `AMD_PRE_NONE |-> ea_reg == {8'h00, x_reg})
        else $error("no-offset indexed address differs from the index");
    a_page_zero: assert property (ok && mode_reg == `AMD_M_DIR_S
        && pre_reg == `AMD_PRE_NONE |-> ea_reg[15:8] == `AMD_PAGE0)
        else $error("short direct address left page zero");
    a_req_hold: assert property (mem_rd_reg && !mem_ack
        |=> mem_rd_reg && $stable(mem_addr_reg))
        else $error("read request dropped or moved before its answer");
    a_halt_pulse: assert property (halt_reg |-> ok ##1 !halt_reg)
        else $error("halt request not a single pulse with done");
    a_bad_group: assert property (take && group >= `AMD_GROUPS
        |=> ##1 done_reg && illegal_reg)
        else $error("unknown group not refused in two cycles");
endmodule

// ### testbench/amd_mem_model.sv
// Behavioural program and data memory answering the decoder's byte reads.
// Assumes one request at a time; each byte is a fixed function of its address.
`timescale 1ns/1ps
module amd_mem_model (
    input  logic        clk_sys,
    input  logic        rstn,
    input  logic [3:0]  wait_cyc,
    input  logic        mem_rd_reg,
    input  logic [15:0] mem_addr_reg,
    output logic [7:0]  mem_rdata,
    output logic        mem_ack
);
    logic [3:0] cnt_reg;

    // Answer after wait_cyc cycles; outside an answer the data toggles, so a
    // decoder that samples without the acknowledge gets a toggling copy of the last answer.
    always_ff @(posedge clk_sys or negedge rstn) begin
        if (!rstn) begin
            {cnt_reg, mem_ack, mem_rdata} <= '0;
        end else if (mem_rd_reg && !mem_ack && cnt_reg == wait_cyc) begin
            mem_ack   <= 1'b1;
            mem_rdata <= (mem_addr_reg[7:0] ^ mem_addr_reg[15:8]) + 8'h01;
            cnt_reg   <= 4'h0;
        end else begin
            mem_ack   <= 1'b0;
            mem_rdata <= ~mem_rdata;
            cnt_reg   <= (mem_rd_reg && !mem_ack) ? cnt_reg + 4'h1 : 4'h0;
        end
    end
endmodule

// ### testbench/amd_decoder_tb.sv
// Self-checking bench for the addressing mode decoder.
// Assumes amd_defines.vh on the include path and the memory model beside it.
`timescale 1ns/1ps
`include "amd_defines.vh"
module amd_decoder_tb;
    logic        clk_sys, rstn, start, rmw_op, mem_ack, mem_rd_reg;
    logic        busy_reg, done_reg, illegal_reg, swi_reg, wait_for_irq_op_reg, halt_reg;
    logic [15:0] opc_pc, mem_addr_reg, next_pc_reg, ea_reg, target_reg;
    logic [7:0]  prebyte, idx_x, idx_y, mem_rdata, imm_reg;
    logic [3:0]  base_mode, group, wait_cyc;
    logic [2:0]  inh_op;
    logic [1:0]  len_reg, irq_mask_reg;
    int          err_total, tests_run, cyc;

    amd_decoder u_amd_decoder (.*);
    amd_mem_model u_amd_mem_model (.*);

    // The clock runs at 200 MHz.
    initial begin
        clk_sys = 1'b0;
        forever #2.5 clk_sys = ~clk_sys;
    end

    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        tests_run++;
        if (got !== exp) begin
            err_total++;
            $display("[FAIL] %0t got %h expected %h", $time, got, exp);
        end
    endtask

    task automatic wrap_up();
        if (err_total == 0 && tests_run > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask

    // One decode; elen of zero means the combination must be refused.
    task automatic op(input logic [7:0] pre, input logic [3:0] md, input logic [3:0] gr,
                      input logic rmw, input logic [2:0] inh, input logic [15:0] pc,
                      input logic [1:0] elen);
        int n;
        @(posedge clk_sys);
        {prebyte, base_mode, group, rmw_op, inh_op, opc_pc} <= {pre, md, gr, rmw, inh, pc};
        start <= 1'b1;
        @(posedge clk_sys);
        start <= 1'b0;
        for (n = 0; n < 60 && done_reg !== 1'b1; n++) @(negedge clk_sys);
        chk(16'(n == 60), 16'h0000);
        chk(16'(illegal_reg), 16'(elen == 2'd0));
        if (elen != 2'd0) begin
            chk(16'(len_reg), 16'(elen));
            chk(next_pc_reg, pc + 16'(elen));
        end
    endtask

    // Descending order so mask clear precedes mask set and both show.
    task automatic t_inherent();
        logic [1:0] mask;
        mask = `AMD_MASK_L3;
        for (int i = 5; i >= 1; i--) begin
            op(`AMD_PRE_NONE, `AMD_M_INH, i > 3 ? `AMD_G_FLAG : `AMD_G_IRQ, 0, 3'(i),
               16'h0200, 2'd1);
            if (i == 5) mask = `AMD_MASK_L0;
            if (i == 4) mask = `AMD_MASK_L3;
            chk(16'(irq_mask_reg), 16'(mask));
            chk(16'({swi_reg, wait_for_irq_op_reg, halt_reg}),
                16'(i == 1 ? 4 : i == 2 ? 2 : i == 3));
        end
    endtask

    task automatic t_direct();
        op(`AMD_PRE_NONE, `AMD_M_IMM, `AMD_G_LOAD, 0, 0, 16'h10ED, 2'd2);
        chk(16'(imm_reg), 16'h00FF);
        op(`AMD_PRE_NONE, `AMD_M_DIR_S, `AMD_G_LOAD, 0, 0, 16'h3040, 2'd2);
        chk(ea_reg, 16'h0072);
        op(`AMD_PRE_NONE, `AMD_M_DIR_L, `AMD_G_CMP, 0, 0, 16'h3040, 2'd3);
        chk(ea_reg, 16'h7273);
    endtask

    task automatic t_indexed();
        op(`AMD_PRE_NONE, `AMD_M_IDX0, `AMD_G_LOAD, 0, 0, 16'h3040, 2'd1);
        chk(ea_reg, 16'h00FF);
        op(`AMD_PRE_Y, `AMD_M_IDX0, `AMD_G_LOAD, 0, 0, 16'h3040, 2'd1);
        chk(ea_reg, 16'h0037);
        op(`AMD_PRE_NONE, `AMD_M_IDX_S, `AMD_G_ARITH, 0, 0, 16'h10ED, 2'd2);
        chk(ea_reg, 16'h01FE);
        op(`AMD_PRE_Y, `AMD_M_IDX_S, `AMD_G_LOGIC, 0, 0, 16'h10ED, 2'd2);
        chk(ea_reg, 16'h0136);
        op(`AMD_PRE_NONE, `AMD_M_IDX_L, `AMD_G_LOAD, 0, 0, 16'h3040, 2'd3);
        chk(ea_reg, 16'h7372);
    endtask

    task automatic t_indirect();
        op(`AMD_PRE_NONE, `AMD_M_IND_S, `AMD_G_LOAD, 0, 0, 16'h3040, 2'd2);
        chk(ea_reg, 16'h0073);
        op(`AMD_PRE_NONE, `AMD_M_IND_L, `AMD_G_LOAD, 0, 0, 16'h3040, 2'd2);
        chk(ea_reg, 16'h7374);
        op(`AMD_PRE_IND, `AMD_M_IDX_S, `AMD_G_LOAD, 0, 0, 16'h3040, 2'd2);
        chk(ea_reg, 16'h0172);
        op(`AMD_PRE_IY, `AMD_M_IDX_S, `AMD_G_LOAD, 0, 0, 16'h3040, 2'd2);
        chk(ea_reg, 16'h00AA);
        op(`AMD_PRE_NONE, `AMD_M_INDX_L, `AMD_G_CMP, 0, 0, 16'h3040, 2'd2);
        chk(ea_reg, 16'h7473);
        op(`AMD_PRE_IND, `AMD_M_DIR_S, `AMD_G_LOAD, 0, 0, 16'h3040, 2'd2);
        chk(ea_reg, 16'h0073);
    endtask

    task automatic t_relative();
        op(`AMD_PRE_NONE, `AMD_M_REL_D, `AMD_G_CBR, 0, 0, 16'h3040, 2'd2);
        chk(target_reg, 16'h30B4);
        op(`AMD_PRE_NONE, `AMD_M_REL_D, `AMD_G_JUMP, 0, 0, 16'h10ED, 2'd2);
        chk(target_reg, 16'h10EE);
        op(`AMD_PRE_IND, `AMD_M_REL_D, `AMD_G_CBR, 0, 0, 16'h3040, 2'd2);
        chk(target_reg, 16'h30B5);
    endtask

    task automatic t_refused();
        op(`AMD_PRE_NONE, `AMD_M_REL_D, `AMD_G_CMP, 0, 0, 16'h3040, 2'd0);
        op(`AMD_PRE_NONE, `AMD_M_DIR_L, `AMD_G_INCDEC, 1, 0, 16'h3040, 2'd0);
        op(`AMD_PRE_NONE, `AMD_M_DIR_L, `AMD_G_JUMP, 0, 0, 16'h3040, 2'd0);
        op(`AMD_PRE_NONE, `AMD_M_IMM, `AMD_G_SHIFT, 0, 0, 16'h3040, 2'd0);
        op(`AMD_PRE_NONE, `AMD_M_INH, 4'hD, 0, `AMD_I_MCLR, 16'h0200, 2'd0);
        chk(16'(irq_mask_reg), 16'(`AMD_MASK_L3));
    endtask

    // A slow memory must only stretch the decode, never change its result.
    task automatic t_slow_memory();
        @(posedge clk_sys);
        wait_cyc <= 4'h3;
        op(`AMD_PRE_NONE, `AMD_M_DIR_L, `AMD_G_LOGIC, 0, 0, 16'h3040, 2'd3);
        chk(ea_reg, 16'h7273);
        @(posedge clk_sys);
        wait_cyc <= 4'h0;
    endtask

    // A hang is cut short well beyond the few hundred cycles the run needs.
    always @(posedge clk_sys) begin
        cyc++;
        if (cyc == 5000) begin
            err_total++;
            wrap_up();
        end
    end

    initial begin
        {start, prebyte, base_mode, group, rmw_op, inh_op, opc_pc, wait_cyc} = '0;
        {rstn, idx_x, idx_y} = {1'b0, 8'hFF, 8'h37};
        {err_total, tests_run, cyc} = '0;
        repeat (3) @(posedge clk_sys);
        rstn <= 1'b1;
        t_inherent();
        t_direct();
        t_indexed();
        t_indirect();
        t_relative();
        t_refused();
        t_slow_memory();
        wrap_up();
    end
endmodule

bind amd_decoder amd_decoder_checker u_amd_decoder_checker (.*);
